//--- canopen_node_defines.svh
`ifndef CANOPEN_NODE_DEFINES_SVH
`define CANOPEN_NODE_DEFINES_SVH

// Object dictionary indices served by this node
`define OD_ERR_REG 16'h1001
`define OD_SYNC_ID 16'h1005
`define OD_SYNC_PERIOD 16'h1006
`define OD_SYNC_WINDOW 16'h1007
`define OD_DEV_NAME 16'h1008
`define OD_HW_VER 16'h1009
`define OD_SW_VER 16'h100a
`define OD_GUARD_TIME 16'h100c
`define OD_LIFE_FACTOR 16'h100d

// Reset values of the communication objects
`define SYNC_ID_RST 32'h0000_0080
`define PERIOD_RST 32'h0000_0000
`define WINDOW_RST 32'h0000_0000
`define GUARD_RST 16'h0000
`define LIFE_RST 8'h00

// Field positions
`define SYNC_PROD_BIT 30
`define CAN_ID_MSB 10
`define ENTRY_NUM_LSB 16
`define ENTRY_CODE_MSB 15

// Time base: clock period and unit lengths in picoseconds / microseconds
`define CLK_PERIOD_PS 5000
`define US_PS 1000000
`define CYC_PER_US (`US_PS / `CLK_PERIOD_PS)
`define US_PER_MS 1000

// Fault entries: {cause number, fault code}
`define FE_GENERIC {8'h04, 16'h1000}
`define FE_OVERCURRENT {8'h02, 16'h2300}
`define FE_VOLTAGE {8'h01, 16'h3100}
`define FE_OVERTEMP {8'h0c, 16'h4200}
`define FE_INTERLOCK {8'h2e, 16'h5540}
`define FE_WATCHDOG {8'h00, 16'h6010}
`define FE_SW_INTERNAL {8'h19, 16'h6100}
`define FE_RATED_CURR {8'h16, 16'h6320}
`define FE_MOTOR_BLOCK {8'h0f, 16'h7121}
`define FE_SENSOR1 {8'h07, 16'h7305}
`define FE_SENSOR2 {8'h08, 16'h7306}
`define FE_SENSOR_N {8'h12, 16'h7307}
`define FE_NVM {8'h15, 16'h7600}
`define FE_LIFE_GUARD {8'h06, 16'h8130}
`define FE_PDO_LATE {8'h11, 16'h8200}
`define FE_PDO_LEN {8'h13, 16'h8210}
`define FE_PDO_EXCESS {8'h14, 16'h8220}
`define FE_SYNC_LEN {8'h1b, 16'h8240}
`define FE_SLIPPAGE {8'h1e, 16'h8400}
`define FE_FOLLOWING {8'h0d, 16'h8611}
`define FE_LIMIT {8'h0a, 16'h8612}

`endif

//--- canopen_node_pkg.sv
package canopen_node_pkg;

    // Fault causes that software or the drive can report
    typedef enum logic [4:0] {
        FK_GENERIC = 5'b00000, FK_OVERCURRENT = 5'b00001, FK_VOLTAGE = 5'b00010,
        FK_OVERTEMP = 5'b00011, FK_INTERLOCK = 5'b00100, FK_WATCHDOG = 5'b00101,
        FK_SW_INTERNAL = 5'b00110, FK_RATED_CURR = 5'b00111, FK_MOTOR_BLOCK = 5'b01000,
        FK_SENSOR1 = 5'b01001, FK_SENSOR2 = 5'b01010, FK_SENSOR_N = 5'b01011,
        FK_NVM = 5'b01100, FK_LIFE_GUARD = 5'b01101, FK_PDO_LATE = 5'b01110,
        FK_PDO_LEN = 5'b01111, FK_PDO_EXCESS = 5'b10000, FK_SYNC_LEN = 5'b10001,
        FK_SLIPPAGE = 5'b10010, FK_FOLLOWING = 5'b10011, FK_LIMIT = 5'b10100
    } fault_kind_t;

    typedef enum logic [1:0] {WIN_OFF = 2'b00, WIN_OPEN = 2'b01, WIN_SHUT = 2'b10} win_state_t;
    typedef enum logic [1:0] {GD_IDLE = 2'b00, GD_RUN = 2'b01, GD_LOST = 2'b10} guard_state_t;

    typedef struct packed {logic wr; logic rd; logic [15:0] index; logic [31:0] wdata;} od_req_t;
    typedef struct packed {logic ack; logic abort; logic [31:0] rdata;} od_rsp_t;
    typedef struct packed {logic valid; logic [10:0] id;} sync_msg_t;
    typedef struct packed {logic valid; fault_kind_t kind;} fault_req_t;
    typedef struct packed {logic valid; logic [31:0] entry;} emcy_t;

    typedef struct packed {
        logic [31:0] sync_id;
        logic [31:0] period;
        logic [31:0] window;
        logic [15:0] guard_time;
        logic [7:0] life;
        logic [10:0] act_id;
        logic act_prod;
        logic [7:0] cyc;
        logic [9:0] ms_div;
        logic [31:0] per_cnt;
        logic [31:0] win_cnt;
        win_state_t win;
        od_rsp_t rsp;
        emcy_t emcy;
        sync_msg_t sync_tx;
        logic tpdo_drop;
        logic rpdo_block;
    } node_st_t;

    typedef struct packed {guard_state_t st; logic [23:0] cnt; logic fail; logic run;} guard_st_t;

endpackage

//--- fault_entry_encoder.sv
`timescale 1ns/1ps
`include "canopen_node_defines.svh"

module fault_entry_encoder (
    // Fault selection
    input wire canopen_node_pkg::fault_kind_t kind,
    input wire logic [7:0] err_class,
    // Assembled history entry
    output logic [31:0] entry
);
    import canopen_node_pkg::*;

    logic [23:0] pair;

    // Cause number and fault code per kind; class byte is the live error register
    always_comb begin
        pair = `FE_GENERIC;
        case (kind)
            FK_OVERCURRENT: pair = `FE_OVERCURRENT;
            FK_VOLTAGE: pair = `FE_VOLTAGE;
            FK_OVERTEMP: pair = `FE_OVERTEMP;
            FK_WATCHDOG: pair = `FE_WATCHDOG;
            FK_SW_INTERNAL: pair = `FE_SW_INTERNAL;
            FK_INTERLOCK: pair = `FE_INTERLOCK;
            FK_RATED_CURR: pair = `FE_RATED_CURR;
            FK_MOTOR_BLOCK: pair = `FE_MOTOR_BLOCK;
            FK_SENSOR1: pair = `FE_SENSOR1;
            FK_SENSOR2: pair = `FE_SENSOR2;
            FK_SENSOR_N: pair = `FE_SENSOR_N;
            FK_NVM: pair = `FE_NVM;
            FK_LIFE_GUARD: pair = `FE_LIFE_GUARD;
            FK_PDO_LATE: pair = `FE_PDO_LATE;
            FK_PDO_LEN: pair = `FE_PDO_LEN;
            FK_PDO_EXCESS: pair = `FE_PDO_EXCESS;
            FK_SYNC_LEN: pair = `FE_SYNC_LEN;
            FK_SLIPPAGE: pair = `FE_SLIPPAGE;
            FK_FOLLOWING: pair = `FE_FOLLOWING;
            FK_LIMIT: pair = `FE_LIMIT;
            default: pair = `FE_GENERIC;
        endcase
        entry = {pair[23:`ENTRY_NUM_LSB], err_class, pair[`ENTRY_CODE_MSB:0]};
    end
endmodule

//--- guard_supervisor.sv
`timescale 1ns/1ps

module guard_supervisor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Time base and protocol events
    input wire logic ms_tick,
    input wire logic rearm,
    input wire logic hb_en,
    // Settings
    input wire logic [15:0] guard_time,
    input wire logic [7:0] life_factor,
    // Status
    output logic fail,
    output logic running
);
    import canopen_node_pkg::*;

    guard_st_t st_r;
    guard_st_t st_nxt;
    logic [23:0] lifetime;

    assign lifetime = guard_time * life_factor;

    // Lifetime counter; starts at the first guard request, rearmed by each one
    always_comb begin
        st_nxt = st_r;
        st_nxt.fail = 1'b0;
        if (lifetime == 24'h0 || hb_en) begin
            st_nxt.st = GD_IDLE;
            st_nxt.cnt = 24'h0;
        end else begin
            case (st_r.st)
                GD_IDLE, GD_LOST: begin
                    if (rearm) begin
                        st_nxt.st = GD_RUN;
                        st_nxt.cnt = 24'h0;
                    end
                end
                GD_RUN: begin
                    if (rearm) begin
                        st_nxt.cnt = 24'h0;
                    end else if (ms_tick) begin
                        if (st_r.cnt >= lifetime - 24'h1) begin
                            st_nxt.st = GD_LOST;
                            st_nxt.fail = 1'b1;
                            st_nxt.cnt = 24'h0;
                        end else begin
                            st_nxt.cnt = st_r.cnt + 24'h1;
                        end
                    end
                end
                default: st_nxt.st = GD_IDLE;
            endcase
        end
        st_nxt.run = (st_nxt.st == GD_RUN);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fail = st_r.fail;
    assign running = st_r.run;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_hb_quiet: assert property (hb_en |=> !fail && !running)
        else $error("guard active while heartbeat enabled");
    a_lifetime_zero: assert property (lifetime == 24'h0 |=> !fail)
        else $error("guard failed with zero lifetime");
endmodule

//--- canopen_comm_node.sv
// What this block does
// - History entry: cause number top byte, class byte next, fault code low half.
// - Class byte copies the error register at the moment of recording.
// - Codes 1000h, 2300h, 3100h, 4200h, 6010h, 6100h for basic faults.
// - Interlock 5540h, rated current missing 6320h, motor blocked 7121h.
// - Sensors 1/2 as 7305h/7306h, others 7307h, storage fault 7600h.
// - Guard 8130h, late PDO 8200h, lengths 8210h/8220h, sync length 8240h.
// - Slippage 8400h, following error 8611h, limit switch 8612h.
// - 11-bit SYNC identifier takes effect only at restart or communication reset.
// - SYNC identifier resets to 80h; other values must be free identifiers.
// - Bit 30 set makes the node SYNC producer with configured identifier.
// - Window elapsed after SYNC: discard pending synchronous TPDOs, send emergency; same-cycle guard loss sends 8130h instead, communication reset skips discard.
// - After window expiry, received PDOs are discarded until next SYNC.
// - Window length zero disables the check; resets to zero.
// - Guard lifetime in ms is guard time times life factor.
// - Heartbeat enabled holds guarding inactive and suppresses its emergency.
// - SYNC id, period, window and guard time are readable and writable.
// - Device name, hardware and software version are read-only strings.
// - Guard time and life factor reset to zero, guarding inactive.
`timescale 1ns/1ps
`include "canopen_node_defines.svh"

module canopen_comm_node #(
    parameter int CYC_PER_US = `CYC_PER_US,
    parameter int US_PER_MS = `US_PER_MS,
    // Identification strings, first four characters; values are arbitrary
    parameter logic [31:0] DEV_NAME_STR = 32'h4e4f4445,
    parameter logic [31:0] HW_VER_STR = 32'h48573031,
    parameter logic [31:0] SW_VER_STR = 32'h53573031
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Object dictionary access
    input wire canopen_node_pkg::od_req_t od_req,
    output canopen_node_pkg::od_rsp_t od_rsp,
    input wire logic [7:0] err_register,
    // Network management
    input wire logic comm_reset,
    input wire logic guard_req,
    input wire logic heartbeat_en,
    output logic guard_running,
    // SYNC traffic
    input wire canopen_node_pkg::sync_msg_t sync_rx,
    output canopen_node_pkg::sync_msg_t sync_tx,
    // Faults and emergency messages
    input wire canopen_node_pkg::fault_req_t fault_in,
    output canopen_node_pkg::emcy_t emcy,
    // PDO gating
    output logic tpdo_discard,
    output logic rpdo_reject
);
    import canopen_node_pkg::*;

    // Prescaler widths are fixed in the state word
    if (CYC_PER_US < 2 || CYC_PER_US > 256) begin : g_bad_cyc
        $error("CYC_PER_US out of range 2..256");
    end
    if (US_PER_MS < 2 || US_PER_MS > 1024) begin : g_bad_ms
        $error("US_PER_MS out of range 2..1024");
    end

    localparam logic [7:0] CYC_LAST = 8'(CYC_PER_US - 1);
    localparam logic [9:0] US_LAST = 10'(US_PER_MS - 1);

    localparam node_st_t ST_RST = '{
        sync_id: `SYNC_ID_RST,
        period: `PERIOD_RST,
        window: `WINDOW_RST,
        guard_time: `GUARD_RST,
        life: `LIFE_RST,
        act_id: 11'(`SYNC_ID_RST),
        act_prod: 1'b0,
        cyc: 8'h00,
        ms_div: 10'h000,
        per_cnt: 32'h0000_0000,
        win_cnt: 32'h0000_0000,
        win: WIN_OFF,
        rsp: '0,
        emcy: '0,
        sync_tx: '0,
        tpdo_drop: 1'b0,
        rpdo_block: 1'b0
    };

    node_st_t st_r;
    node_st_t st_nxt;

    logic us_tick;
    logic ms_tick;
    logic rx_hit;
    logic prod_due;
    logic sync_evt;
    logic win_expire;
    logic guard_fail;
    fault_kind_t sel_kind;
    logic sel_valid;
    logic [31:0] enc_entry;

    // Microsecond and millisecond strobes from the core clock
    assign us_tick = (st_r.cyc == CYC_LAST);
    assign ms_tick = us_tick && (st_r.ms_div == US_LAST);

    // SYNC seen on the bus under the active identifier, or produced here
    assign rx_hit = sync_rx.valid && (sync_rx.id == st_r.act_id);
    assign prod_due = st_r.act_prod && (st_r.period != 32'h0) && us_tick
        && (st_r.per_cnt >= st_r.period - 32'h1);
    assign sync_evt = rx_hit || prod_due;

    // Window runs out on the microsecond in which the count reaches the length
    assign win_expire = (st_r.win == WIN_OPEN) && (st_r.window != 32'h0) && !sync_evt
        && us_tick && (st_r.win_cnt + 32'h1 >= st_r.window);

    // Emergency source: guard loss first, then window expiry, then external faults.
    // A lower source arriving in the same cycle as a higher one is not queued.
    always_comb begin
        sel_valid = 1'b1;
        sel_kind = FK_GENERIC;
        if (guard_fail) begin
            sel_kind = FK_LIFE_GUARD;
        end else if (win_expire) begin
            sel_kind = FK_PDO_LATE;
        end else if (fault_in.valid) begin
            sel_kind = fault_in.kind;
        end else begin
            sel_valid = 1'b0;
        end
    end

    fault_entry_encoder u_encoder (
        .kind(sel_kind),
        .err_class(err_register),
        .entry(enc_entry)
    );

    guard_supervisor u_guard (
        .core_clk(core_clk),
        .nrst(nrst),
        .ms_tick(ms_tick),
        .rearm(guard_req),
        .hb_en(heartbeat_en),
        .guard_time(st_r.guard_time),
        .life_factor(st_r.life),
        .fail(guard_fail),
        .running(guard_running)
    );

    // Next state: time base, object access, SYNC producer, window, emergencies
    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp = '0;
        st_nxt.emcy.valid = 1'b0;
        st_nxt.sync_tx.valid = 1'b0;
        st_nxt.tpdo_drop = 1'b0;

        // Time base
        if (us_tick) begin
            st_nxt.cyc = 8'h00;
            st_nxt.ms_div = ms_tick ? 10'h000 : st_r.ms_div + 10'h001;
        end else begin
            st_nxt.cyc = st_r.cyc + 8'h01;
        end

        // Object access; a write wins when both strobes are set
        if (od_req.wr) begin
            st_nxt.rsp.ack = 1'b1;
            if (od_req.index == `OD_SYNC_ID) begin
                st_nxt.sync_id = od_req.wdata;
            end else if (od_req.index == `OD_SYNC_PERIOD) begin
                st_nxt.period = od_req.wdata;
            end else if (od_req.index == `OD_SYNC_WINDOW) begin
                st_nxt.window = od_req.wdata;
            end else if (od_req.index == `OD_GUARD_TIME) begin
                st_nxt.guard_time = od_req.wdata[15:0];
            end else if (od_req.index == `OD_LIFE_FACTOR) begin
                st_nxt.life = od_req.wdata[7:0];
            end else begin
                st_nxt.rsp.abort = 1'b1;
            end
        end else if (od_req.rd) begin
            st_nxt.rsp.ack = 1'b1;
            if (od_req.index == `OD_SYNC_ID) begin
                st_nxt.rsp.rdata = st_r.sync_id;
            end else if (od_req.index == `OD_SYNC_PERIOD) begin
                st_nxt.rsp.rdata = st_r.period;
            end else if (od_req.index == `OD_SYNC_WINDOW) begin
                st_nxt.rsp.rdata = st_r.window;
            end else if (od_req.index == `OD_GUARD_TIME) begin
                st_nxt.rsp.rdata = {16'h0000, st_r.guard_time};
            end else if (od_req.index == `OD_LIFE_FACTOR) begin
                st_nxt.rsp.rdata = {24'h000000, st_r.life};
            end else if (od_req.index == `OD_ERR_REG) begin
                st_nxt.rsp.rdata = {24'h000000, err_register};
            end else if (od_req.index == `OD_DEV_NAME) begin
                st_nxt.rsp.rdata = DEV_NAME_STR;
            end else if (od_req.index == `OD_HW_VER) begin
                st_nxt.rsp.rdata = HW_VER_STR;
            end else if (od_req.index == `OD_SW_VER) begin
                st_nxt.rsp.rdata = SW_VER_STR;
            end else begin
                st_nxt.rsp.abort = 1'b1;
            end
        end

        // SYNC producer; period is read live, so a new period applies to the count already running
        if (!st_r.act_prod || st_r.period == 32'h0) begin
            st_nxt.per_cnt = 32'h0000_0000;
        end else if (prod_due) begin
            st_nxt.per_cnt = 32'h0000_0000;
            st_nxt.sync_tx.valid = 1'b1;
            st_nxt.sync_tx.id = st_r.act_id;
        end else if (us_tick) begin
            st_nxt.per_cnt = st_r.per_cnt + 32'h1;
        end

        // Synchronous window
        if (st_r.window == 32'h0) begin
            st_nxt.win = WIN_OFF;
            st_nxt.rpdo_block = 1'b0;
            st_nxt.win_cnt = 32'h0000_0000;
        end else if (sync_evt) begin
            st_nxt.win = WIN_OPEN;
            st_nxt.win_cnt = 32'h0000_0000;
            st_nxt.rpdo_block = 1'b0;
        end else if (win_expire) begin
            st_nxt.win = WIN_SHUT;
            st_nxt.tpdo_drop = 1'b1;
            st_nxt.rpdo_block = 1'b1;
        end else if (st_r.win == WIN_OPEN && us_tick) begin
            st_nxt.win_cnt = st_r.win_cnt + 32'h1;
        end

        // Emergency entry, class byte captured now
        if (sel_valid) begin
            st_nxt.emcy.valid = 1'b1;
            st_nxt.emcy.entry = enc_entry;
        end

        // Communication reset adopts the stored identifier and restarts timing
        if (comm_reset) begin
            st_nxt.act_id = st_r.sync_id[`CAN_ID_MSB:0];
            st_nxt.act_prod = st_r.sync_id[`SYNC_PROD_BIT];
            st_nxt.per_cnt = 32'h0000_0000;
            st_nxt.win = WIN_OFF;
            st_nxt.win_cnt = 32'h0000_0000;
            st_nxt.rpdo_block = 1'b0;
            // A communication reset drops the discard pulse so discard never stands without rejection
            st_nxt.tpdo_drop = 1'b0;
        end
    end

    // State register; restart loads the stored defaults
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign od_rsp = st_r.rsp;
    assign sync_tx = st_r.sync_tx;
    assign emcy = st_r.emcy;
    assign tpdo_discard = st_r.tpdo_drop;
    assign rpdo_reject = st_r.rpdo_block;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_entry_class: assert property (emcy.valid |-> emcy.entry[23:16] == $past(err_register))
        else $error("emergency class byte differs from error register");
    a_guard_code: assert property (guard_fail |=> emcy.valid
        && emcy.entry == {8'h06, $past(err_register), 16'h8130})
        else $error("guard loss did not raise code 8130");
    a_window_drop: assert property (tpdo_discard |-> rpdo_reject && emcy.valid
        && (emcy.entry[15:0] == 16'h8200 || emcy.entry[15:0] == 16'h8130))
        else $error("window expiry without emergency or rejection");
    a_reject_hold: assert property (rpdo_reject && !sync_evt && !comm_reset
        && st_r.window != 32'h0 |=> rpdo_reject)
        else $error("PDO rejection ended before SYNC");
    a_window_off: assert property (st_r.window == 32'h0 |=> !tpdo_discard && !rpdo_reject)
        else $error("window acted while disabled");
    a_id_deferred: assert property (od_req.wr && od_req.index == `OD_SYNC_ID && !comm_reset
        |=> $stable(st_r.act_id) && $stable(st_r.act_prod))
        else $error("SYNC identifier used before communication reset");
    a_id_reload: assert property (comm_reset |=>
        st_r.act_id == $past(st_r.sync_id[`CAN_ID_MSB:0])
        && st_r.act_prod == $past(st_r.sync_id[`SYNC_PROD_BIT]))
        else $error("communication reset did not adopt identifier");
    a_prod_gate: assert property (sync_tx.valid |-> $past(st_r.act_prod)
        && $past(st_r.period) != 32'h0 && sync_tx.id == $past(st_r.act_id))
        else $error("SYNC produced without producer bit or period");
    a_sync_clear: assert property (sync_evt && !comm_reset |=> !rpdo_reject && !tpdo_discard)
        else $error("SYNC did not clear PDO rejection");
    // Ack stands one cycle unless a back-to-back access was taken meanwhile
    a_od_answer: assert property ((od_req.wr || od_req.rd) |=> od_rsp.ack
        ##1 (!od_rsp.ack || $past(od_req.wr || od_req.rd)))
        else $error("object access not answered in one cycle");
    a_ro_string: assert property (od_req.wr && (od_req.index == `OD_DEV_NAME
        || od_req.index == `OD_HW_VER || od_req.index == `OD_SW_VER) |=> od_rsp.abort)
        else $error("write to read-only string accepted");

    c_sync_made: cover property (sync_tx.valid ##[1:300] sync_tx.valid);
    c_window_out: cover property (sync_evt ##[1:300] tpdo_discard);
    c_guard_lost: cover property (guard_running ##[1:1000] guard_fail);
endmodule

//--- can_master.sv
`timescale 1ns/1ps
module can_master (
    // Clock
    input wire logic core_clk,
    // Frames toward the node
    output canopen_node_pkg::sync_msg_t sync_rx,
    output logic guard_req
);
    initial begin
        sync_rx = '0;
        guard_req = 1'b0;
    end
    // One-cycle frame; idle id flips so a stale id never matches
    task automatic send_sync(input logic [10:0] id);
        @(negedge core_clk);
        sync_rx <= {1'b1, id};
        @(negedge core_clk);
        sync_rx <= {1'b0, ~id};
    endtask
    // Node guard request frame
    task automatic send_guard();
        @(negedge core_clk);
        guard_req <= 1'b1;
        @(negedge core_clk);
        guard_req <= 1'b0;
    endtask
endmodule

//--- tb_canopen_sync_guard_error_unit.sv
`timescale 1ns/1ps
`include "canopen_node_defines.svh"
module tb_canopen_sync_guard_error_unit;
    import canopen_node_pkg::*;
    logic core_clk, nrst, comm_reset, heartbeat_en, guard_req, guard_running;
    logic tpdo_discard, rpdo_reject;
    logic [7:0] err_register;
    logic [15:0] lf = 16'h82d6;
    logic [15:0] e;
    od_req_t od_req;
    od_rsp_t od_rsp;
    sync_msg_t sync_rx, sync_tx;
    fault_req_t fault_in;
    emcy_t emcy;
    int errors = 0;
    int n_compared = 0;
    int t;
    logic [31:0] regs[logic [15:0]];
    logic [15:0] ro[4] = '{16'h1008, 16'h1009, 16'h100a, 16'h1234};
    logic [15:0] rw[5] = '{16'h1005, 16'h1006, 16'h1007, 16'h100c, 16'h100d};
    logic [23:0] fe[21] = '{`FE_GENERIC, `FE_OVERCURRENT, `FE_VOLTAGE, `FE_OVERTEMP,
        `FE_INTERLOCK, `FE_WATCHDOG, `FE_SW_INTERNAL, `FE_RATED_CURR, `FE_MOTOR_BLOCK,
        `FE_SENSOR1, `FE_SENSOR2, `FE_SENSOR_N, `FE_NVM, `FE_LIFE_GUARD, `FE_PDO_LATE,
        `FE_PDO_LEN, `FE_PDO_EXCESS, `FE_SYNC_LEN, `FE_SLIPPAGE, `FE_FOLLOWING, `FE_LIMIT};

    // Short time base so guard and window counts stay small
    canopen_comm_node #(.CYC_PER_US(2), .US_PER_MS(2)) uut (.core_clk(core_clk), .nrst(nrst),
        .od_req(od_req), .od_rsp(od_rsp), .err_register(err_register),
        .comm_reset(comm_reset), .guard_req(guard_req), .heartbeat_en(heartbeat_en),
        .guard_running(guard_running), .sync_rx(sync_rx), .sync_tx(sync_tx),
        .fault_in(fault_in), .emcy(emcy), .tpdo_discard(tpdo_discard),
        .rpdo_reject(rpdo_reject));
    can_master pm (.core_clk(core_clk), .sync_rx(sync_rx), .guard_req(guard_req));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    function automatic logic ev(int s);
        return s == 0 ? od_rsp.ack : s == 1 ? emcy.valid : sync_tx.valid;
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Bounded wait for an event pulse; running out ends the run
    task automatic wait_ev(input int s, input int lim, output int n);
        for (n = 0; n < lim && ev(s) !== 1'b1; n++) @(negedge core_clk);
        if (n == lim) begin
            errors++;
            $display("MISMATCH t=%0t wait ran out", $time);
            finish_test();
        end
    endtask
    task automatic quiet(input int s, input int n);
        logic q = 1'b0;
        repeat (n) begin
            @(negedge core_clk);
            q |= ev(s) | rpdo_reject;
        end
        chk(q, 0);
    endtask
    // Object access: strobe one cycle, wait for ack, leave a gap cycle
    task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
        output logic [32:0] r);
        od_req <= {w, !w, i, d};
        @(negedge core_clk);
        od_req <= '0;
        wait_ev(0, 4, t);
        r = {od_rsp.abort, od_rsp.rdata};
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [15:0] i, input logic [31:0] d, input logic ab);
        logic [32:0] r;
        acc(1'b1, i, d, r);
        chk(r[32], ab);
        if (!ab) regs[i] = d & (i == 16'h100c ? 32'hffff : i == 16'h100d ? 32'hff : '1);
    endtask
    task automatic rd(input logic [15:0] i);
        logic [32:0] r;
        acc(1'b0, i, 0, r);
        chk(r, {1'b0, regs[i]});
    endtask

    initial begin
        nrst = 1'b0;
        od_req = '0;
        err_register = '0;
        comm_reset = 1'b0;
        heartbeat_en = 1'b0;
        fault_in = '0;
        regs = '{16'h1005: 32'h80, 16'h1006: 0, 16'h1007: 0, 16'h100c: 0, 16'h100d: 0};
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        foreach (regs[i]) rd(i);
        foreach (ro[i]) wr(ro[i], {rnd(), rnd()}, 1'b1);
        repeat (3) foreach (rw[i]) begin
            wr(rw[i], {rnd(), rnd()}, 1'b0);
            rd(rw[i]);
        end
        $display("test objects done");
        // Every fault kind with a random error register
        for (int k = 0; k < 21; k++) begin
            e = rnd();
            err_register = e[7:0];
            fault_in = {1'b1, fault_kind_t'(k)};
            @(negedge core_clk);
            fault_in = '0;
            wait_ev(1, 4, t);
            chk(emcy.entry, {fe[k][23:16], err_register, fe[k][15:0]});
            @(negedge core_clk);
        end
        regs[16'h1001] = {24'h000000, err_register};
        rd(16'h1001);
        $display("test faults done");
        // Window of 5 us is 10 clocks here
        wr(16'h1007, 5, 1'b0);
        pm.send_sync(11'h081);
        quiet(1, 20);
        pm.send_sync(11'h080);
        wait_ev(1, 30, t);
        chk({tpdo_discard, rpdo_reject, emcy.entry[15:0], t inside {[6:13]}}, 19'h70401);
        @(negedge core_clk);
        chk(rpdo_reject, 1);
        pm.send_sync(11'h080);
        chk(rpdo_reject, 0);
        wr(16'h1007, 0, 1'b0);
        quiet(1, 30);
        $display("test window done");
        // Lifetime 3 ms times 2 is 24 clocks here
        wr(16'h100c, 3, 1'b0);
        wr(16'h100d, 2, 1'b0);
        pm.send_guard();
        @(negedge core_clk);
        chk(guard_running, 1);
        wait_ev(1, 60, t);
        chk({emcy.entry[15:0], t inside {[16:32]}}, 17'h10261);
        heartbeat_en = 1'b1;
        pm.send_guard();
        quiet(1, 60);
        chk(guard_running, 0);
        heartbeat_en = 1'b0;
        $display("test guard done");
        // Producer with a free identifier and a 1000 us period
        wr(16'h1005, 32'h4000_00a5, 1'b0);
        wr(16'h1006, 1000, 1'b0);
        quiet(2, 2100);
        comm_reset = 1'b1;
        @(negedge core_clk);
        comm_reset = 1'b0;
        wait_ev(2, 2010, t);
        chk(sync_tx.id, 11'h0a5);
        @(negedge core_clk);
        wait_ev(2, 2010, t);
        chk(t, 1999);
        wr(16'h1006, 0, 1'b0);
        comm_reset = 1'b1;
        @(negedge core_clk);
        comm_reset = 1'b0;
        quiet(2, 4100);
        $display("test producer done");
        finish_test();
    end
endmodule
